// ==== max_limit_defines.svh ====
`ifndef MAX_LIMIT_DEFINES_SVH
`define MAX_LIMIT_DEFINES_SVH

// command codes decoded by this block
`define ML_CODE_SET48 8'h37
`define ML_CODE_NATIVE48 8'h27
`define ML_CODE_SET28 8'hf9
`define ML_CODE_NATIVE28 8'hf8

// field positions in the device and sector count bytes
`define ML_DEV_LBA_BIT 6
`define ML_DEV_SEL_BIT 4
`define ML_DEV_HEAD_MSB 3
`define ML_SECT_NV_BIT 0

// largest address reachable by 28-bit commands
`define ML_MAX28 48'h0000_0fff_ffff

// fixed geometry returned in chs mode
`define ML_CHS_MAX_SECT 8'h3f
`define ML_CHS_MAX_HEAD 4'hf

// reset values
`define ML_RST_BYTE 8'h00
`define ML_RST_ADDR 48'h0000_0000_0000

`endif

// ==== max_limit_pkg.sv ====
package max_limit_pkg;

    // one low/mid/high byte triple of the task file
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] mid;
        logic [7:0] low;
    } tf_bytes_t;

    // one command as written by the host
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] sect;
        logic [7:0] dev;
        tf_bytes_t cur;
        tf_bytes_t prev;
    } tf_cmd_t;

    // command classes of interest
    typedef enum logic [2:0] {
        KIND_OTHER = 3'b000,
        KIND_NATIVE28 = 3'b001,
        KIND_NATIVE48 = 3'b010,
        KIND_SET28 = 3'b011,
        KIND_SET48 = 3'b100
    } cmd_kind_t;

endpackage

// ==== limit_store.sv ====
`timescale 1ns/1ps
`default_nettype none

module limit_store
    import max_limit_pkg::*;
#(
    parameter int AW = 48
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // power-on or hardware reset event
    input wire logic hw_reset,
    // load request
    input wire logic load,
    input wire logic [AW-1:0] load_val,
    input wire logic load_nv,
    input wire logic mark_nv,
    // native capacity of the media
    input wire logic [AW-1:0] native_max,
    // stored limit and one-shot state
    output logic [AW-1:0] limit,
    output logic nv_used
);
    logic valid_q;
    logic nv_q;
    logic nv_used_q;
    logic [AW-1:0] val_q;

    // limit value and its retention kind
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            valid_q <= 1'b0;
            nv_q <= 1'b0;
            val_q <= '0;
        end else if (hw_reset) begin
            if (!nv_q) begin
                valid_q <= 1'b0;
            end
        end else if (load) begin
            valid_q <= 1'b1;
            nv_q <= load_nv;
            val_q <= load_val;
        end
    end

    // one nonvolatile set per reset period
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            nv_used_q <= 1'b0;
        end else if (hw_reset) begin
            nv_used_q <= 1'b0;
        end else if (mark_nv) begin
            nv_used_q <= 1'b1;
        end
    end

    // without a stored limit the native capacity applies
    assign limit = valid_q ? val_q : native_max;
    assign nv_used = nv_used_q;

endmodule

`default_nettype wire

// ==== max_limit_cmd.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "max_limit_defines.svh"

// Overview of operation
// - device byte bit 6 picks chs when clear, lba when set
// - device byte bit 4 addresses master or slave; only selected acts
// - 28-bit lba set returns adjusted max lba across low/mid/high/head
// - 28-bit chs set returns sector 63, head 15, new cylinder
// - code 37h decodes as the 48-bit address limit set
// - accesses above an accepted limit are aborted
// - limit above 268,435,455 updates 48-bit words only
// - limit up to 268,435,455 updates both capacity word sets
// - abort when above capacity or not right after native read
// - 48-bit set aborted when a 28-bit protected area was made since the last hardware reset
// - abort while limit security is locked or frozen
// - nonvolatile request in offset mode is aborted
// - second nonvolatile 48-bit set aborted until next reset
// - option bit clear gives volatile limit, set keeps it
// - readback gives bits 23-0 with hob clear, 47-24 with set
module max_limit_cmd
    import max_limit_pkg::*;
#(
    parameter int AW = 48
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // power-on or hardware reset event, same clock
    input wire logic hw_reset,
    // jumper pin saying this drive is the slave
    input wire logic slave_pin,
    // command strobe from task-file logic, same clock
    input wire logic cmd_valid,
    input wire tf_cmd_t cmd,
    // drive configuration and security state
    input wire logic [AW-1:0] native_max,
    input wire logic offset_mode,
    input wire logic sm_locked,
    input wire logic sm_frozen,
    // media access check
    input wire logic acc_valid,
    input wire logic [AW-1:0] acc_addr,
    output logic acc_abort_q,
    // command completion
    output logic cmd_done_q,
    output logic cmd_abort_q,
    // returned task-file bytes, hob clear and hob set
    output tf_bytes_t ret_cur_q,
    output tf_bytes_t ret_prev_q,
    output logic [3:0] ret_head_q,
    // reported capacity words
    output logic [AW-1:0] cap48_q,
    output logic [27:0] cap28_q
);
    logic slave_meta_q;
    logic slave_q;
    logic last48_q;
    logic last28_q;
    logic hpa28_q;
    logic init_q;
    logic [AW-1:0] limit;
    logic nv_used;
    cmd_kind_t kind;
    logic sel;
    logic req;
    logic lba;
    logic nv;
    logic [15:0] cyl;
    logic [AW-1:0] v48;
    logic [AW-1:0] v28;
    logic [AW-1:0] chs_lba;
    logic abort48;
    logic abort28;
    logic ok48;
    logic ok28;
    logic [AW-1:0] new_val;

    // jumper is asynchronous to sys_clk
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            slave_meta_q <= 1'b0;
            slave_q <= 1'b0;
        end else begin
            slave_meta_q <= slave_pin;
            slave_q <= slave_meta_q;
        end
    end

    // command decode
    always_comb begin
        unique case (cmd.code)
            `ML_CODE_SET48: kind = KIND_SET48;
            `ML_CODE_NATIVE48: kind = KIND_NATIVE48;
            `ML_CODE_SET28: kind = KIND_SET28;
            `ML_CODE_NATIVE28: kind = KIND_NATIVE28;
            default: kind = KIND_OTHER;
        endcase
    end

    assign sel = cmd.dev[`ML_DEV_SEL_BIT] == slave_q;
    // commands are ignored during a reset and until the capacity reload after it
    assign req = cmd_valid && sel && init_q && !hw_reset;
    assign lba = cmd.dev[`ML_DEV_LBA_BIT];
    assign nv = cmd.sect[`ML_SECT_NV_BIT];
    assign cyl = {cmd.cur.high, cmd.cur.mid};

    // limit bytes as the host lays them out
    assign v48 = {cmd.prev, cmd.cur};
    // chs limit is the last block of the given cylinder
    assign chs_lba = AW'(({32'h0, cyl} + 48'h1)
        * ({44'h0, `ML_CHS_MAX_HEAD} + 48'h1)
        * {40'h0, `ML_CHS_MAX_SECT}) - AW'(1);
    assign v28 = lba ? {20'h0, cmd.dev[`ML_DEV_HEAD_MSB:0], cmd.cur}
                     : chs_lba;

    // abort causes for the 48-bit set
    assign abort48 = !last48_q || (v48 > native_max) || hpa28_q
        || sm_locked || sm_frozen || (nv && offset_mode)
        || (nv && nv_used);
    // the 28-bit set follows the same capacity and security checks
    assign abort28 = !last28_q || (v28 > native_max) || sm_locked
        || sm_frozen || (nv && offset_mode);
    assign ok48 = req && kind == KIND_SET48 && !abort48;
    assign ok28 = req && kind == KIND_SET28 && !abort28;
    assign new_val = ok48 ? v48 : v28;

    limit_store #(
        .AW(AW)
    ) u_store (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .hw_reset(hw_reset),
        .load(ok48 || ok28),
        .load_val(new_val),
        .load_nv(nv),
        .mark_nv(ok48 && nv),
        .native_max(native_max),
        .limit(limit),
        .nv_used(nv_used)
    );

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            last48_q <= 1'b0;
            last28_q <= 1'b0;
        end else if (hw_reset) begin
            last48_q <= 1'b0;
            last28_q <= 1'b0;
        end else if (req) begin
            last48_q <= kind == KIND_NATIVE48;
            last28_q <= kind == KIND_NATIVE28;
        end
    end

    // protected area made by the 28-bit set, cleared by any hardware reset even if the limit is kept
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hpa28_q <= 1'b0;
        end else if (hw_reset) begin
            hpa28_q <= 1'b0;
        end else if (ok28) begin
            hpa28_q <= 1'b1;
        end
    end

    // completion strobe one cycle after the command
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_done_q <= 1'b0;
            cmd_abort_q <= 1'b0;
        end else begin
            cmd_done_q <= req;
            cmd_abort_q <= req && ((kind == KIND_SET48 && abort48)
                || (kind == KIND_SET28 && abort28));
        end
    end

    // returned bytes; left alone on abort
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ret_cur_q <= '0;
            ret_prev_q <= '0;
            ret_head_q <= 4'h0;
        end else if (ok48) begin
            // hob clear gives 23-0, hob set gives 47-24
            ret_cur_q <= v48[23:0];
            ret_prev_q <= v48[47:24];
        end else if (ok28 && lba) begin
            ret_cur_q <= v28[23:0];
            ret_head_q <= v28[27:24];
        end else if (ok28) begin
            // fixed sector and head, new cylinder
            ret_cur_q <= {cyl, `ML_CHS_MAX_SECT};
            ret_head_q <= `ML_CHS_MAX_HEAD;
        end
    end

    // capacity words; reloaded from the store after any reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            init_q <= 1'b0;
            cap48_q <= `ML_RST_ADDR;
            cap28_q <= 28'h0;
        end else if (hw_reset) begin
            init_q <= 1'b0;
        end else if (!init_q) begin
            init_q <= 1'b1;
            cap48_q <= limit;
            // clamp to what 28-bit commands can reach
            cap28_q <= (limit > `ML_MAX28) ? 28'(`ML_MAX28) : limit[27:0];
        end else if (ok48 || ok28) begin
            // 28-bit words only follow small limits
            cap48_q <= new_val;
            if (new_val <= `ML_MAX28) begin
                cap28_q <= new_val[27:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            acc_abort_q <= 1'b0;
        end else begin
            acc_abort_q <= acc_valid && (acc_addr > limit);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_set48;
        req && kind == KIND_SET48;
    endsequence

    // a reset in between would drop a volatile limit, so it is excluded
    sequence s_accept_then_probe;
        ok48 ##1 !hw_reset ##1 (acc_valid && acc_addr > $past(v48, 2));
    endsequence

    not_native_a: assert property (
        s_set48 ##0 !last48_q |=> cmd_done_q && cmd_abort_q)
        else $error("set without native read not aborted");
    hpa28_abort_a: assert property (
        s_set48 ##0 hpa28_q |=> cmd_abort_q && $stable(cap48_q))
        else $error("set after 28-bit area not aborted");
    locked_abort_a: assert property (
        s_set48 ##0 (sm_locked || sm_frozen) |=> cmd_abort_q)
        else $error("set while locked or frozen not aborted");
    offset_nv_a: assert property (
        s_set48 ##0 (nv && offset_mode) |=> cmd_abort_q)
        else $error("nonvolatile set in offset mode accepted");
    nv_twice_a: assert property (
        s_set48 ##0 (nv && nv_used) |=> cmd_abort_q)
        else $error("second nonvolatile set accepted");
    access_reject_a: assert property (
        s_accept_then_probe |=> acc_abort_q)
        else $error("access above new limit not rejected");
    cap_split_a: assert property (
        ok48 && v48 > `ML_MAX28 |=> cap48_q == $past(v48)
        && $stable(cap28_q))
        else $error("large limit changed 28-bit words");
    cap_both_a: assert property (
        ok48 && v48 <= `ML_MAX28 |=> cap28_q == $past(v48[27:0])
        && cap48_q == $past(v48))
        else $error("small limit not in both word sets");
    hob_bytes_a: assert property (
        ok48 |=> ret_prev_q == $past(v48[47:24])
        && ret_cur_q == $past(v48[23:0]) && !cmd_abort_q)
        else $error("returned limit bytes wrong");
    chs_return_a: assert property (
        ok28 && !lba |=> ret_cur_q.low == `ML_CHS_MAX_SECT
        && ret_head_q == `ML_CHS_MAX_HEAD
        && {ret_cur_q.high, ret_cur_q.mid} == $past(cyl))
        else $error("chs return values wrong");
    lba28_return_a: assert property (
        ok28 && lba |=> {ret_head_q, ret_cur_q} == $past(v28[27:0]))
        else $error("28-bit lba return wrong");
    unselected_a: assert property (
        cmd_valid && !sel |=> !cmd_done_q)
        else $error("unselected drive answered");

endmodule

`default_nettype wire

// ==== ata_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ata_host_model
    import max_limit_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // command strobe and task-file bytes
    output logic cmd_valid,
    output tf_cmd_t cmd
);
    // bus idle at start
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end

    // one command, strobed for a single cycle
    task automatic send(input logic [7:0] code, input logic [7:0] sect,
                        input logic [7:0] dev, input logic [47:0] lim);
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd.code = code;
        cmd.sect = sect;
        cmd.dev = dev;
        // low bytes current, high bytes previous
        cmd.cur = lim[23:0];
        cmd.prev = lim[47:24];
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        // stale bytes inverted so nothing leans on a held value
        cmd = ~cmd;
    endtask

    // native read issued directly before the set
    task automatic set48(input logic [47:0] lim, input logic [7:0] sect);
        send(8'h27, 8'h00, 8'h40, 48'h0);
        send(8'h37, sect, 8'h40, lim);
    endtask
endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "max_limit_defines.svh"

module tb;
    import max_limit_pkg::*;
    localparam logic [47:0] native_cap = 48'h0000_4000_0000;
    typedef struct packed {
        logic ab;
        logic [1:0] k;
        tf_bytes_t cur;
        logic [3:0] hd;
        logic [47:0] c48;
        logic [27:0] c28;
    } exp_t;
    logic sys_clk, rstn, hw_reset, slave_pin, acc_valid, cmd_valid;
    logic offset_mode, sm_locked, sm_frozen, acc_abort_q, cmd_done_q;
    logic cmd_abort_q, nv_lim, acc_now, acc_pend;
    logic [47:0] acc_addr, lim, l2, cap48_q;
    logic [31:0] r;
    logic [27:0] cap28_q;
    logic [3:0] ret_head_q;
    tf_cmd_t cmd;
    tf_bytes_t ret_cur_q, ret_prev_q;
    int fail_count, cmp_count;
    integer seed;
    exp_t expq[$];
    exp_t e;
    logic accq[$];

    max_limit_cmd #(.AW(48)) u_max_limit_cmd (.sys_clk(sys_clk),
        .rstn(rstn), .hw_reset(hw_reset), .slave_pin(slave_pin),
        .cmd_valid(cmd_valid), .cmd(cmd), .native_max(native_cap),
        .offset_mode(offset_mode), .sm_locked(sm_locked),
        .sm_frozen(sm_frozen), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_abort_q(acc_abort_q), .cmd_done_q(cmd_done_q),
        .cmd_abort_q(cmd_abort_q), .ret_cur_q(ret_cur_q),
        .ret_prev_q(ret_prev_q), .ret_head_q(ret_head_q),
        .cap48_q(cap48_q), .cap28_q(cap28_q));

    ata_host_model u_ata_host_model (.sys_clk(sys_clk),
        .cmd_valid(cmd_valid), .cmd(cmd));

    // 100 mhz clock
    always #5 sys_clk = ~sys_clk;

    function automatic logic [27:0] cut28(input logic [47:0] v);
        return (v > `ML_MAX28) ? 28'hfff_ffff : v[27:0];
    endfunction

    task automatic chk(input string n, input logic [63:0] x,
                       input logic [63:0] g);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // note one expected completion against the current limit
    task automatic note(input logic ab, input logic [1:0] k,
                        input logic [23:0] cur, input logic [3:0] hd);
        expq.push_back({ab, k, cur, hd, lim, cut28(lim)});
    endtask

    task automatic set48(input logic [47:0] v, input logic nv,
                         input logic ab);
        note(1'b0, 2'd0, 24'h0, 4'h0);
        if (!ab) begin
            lim = v;
            nv_lim = nv;
        end
        note(ab, 2'd1, lim[23:0], 4'h0);
        u_ata_host_model.set48(v, {7'h0, nv});
    endtask

    task automatic probe(input logic [47:0] a, input logic ab);
        @(negedge sys_clk);
        accq.push_back(ab);
        acc_valid = 1'b1;
        acc_addr = a;
        @(negedge sys_clk);
        acc_valid = 1'b0;
        acc_addr = ~a;
    endtask

    // volatile limit falls back to native capacity
    task automatic hw_pulse;
        @(negedge sys_clk);
        hw_reset = 1'b1;
        @(negedge sys_clk);
        hw_reset = 1'b0;
        if (!nv_lim) lim = native_cap;
        repeat (3) @(negedge sys_clk);
    endtask

    // oldest note checked whenever a completion shows
    always @(posedge sys_clk) begin
        acc_now = acc_valid;
        #1;
        if (cmd_done_q === 1'b1) begin
            if (expq.size() == 0) begin
                chk("unexpected done", 64'h0, 64'h1);
            end else begin
                e = expq.pop_front();
                chk("abort", e.ab, cmd_abort_q);
                chk("cap48", e.c48, cap48_q);
                chk("cap28", e.c28, cap28_q);
                if (e.k != 2'd0 && !e.ab) chk("cur", e.cur, ret_cur_q);
                if (e.k == 2'd1 && !e.ab) begin
                    chk("prev", lim[47:24], ret_prev_q);
                end
                if (e.k == 2'd2) chk("head", e.hd, ret_head_q);
            end
        end
        // the abort pulse answers the edge that sampled the probe
        acc_pend = acc_now;
        if (acc_pend) begin
            chk("access abort", accq.pop_front(), acc_abort_q);
        end
    end

    // hang guard, well beyond the sequence length
    initial begin
        #200000;
        fail_count++;
        report_and_stop;
    end

    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        {hw_reset, slave_pin, acc_valid, offset_mode} = 4'h0;
        {sm_locked, sm_frozen, acc_pend, nv_lim} = 4'h0;
        acc_addr = 48'h0;
        seed = 32'hd8c6;
        lim = native_cap;
        repeat (4) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("cap48 init", native_cap, cap48_q);
        chk("cap28 init", 28'hfff_ffff, cap28_q);
        note(1'b1, 2'd1, 24'h0, 4'h0);
        u_ata_host_model.send(8'h37, 8'h0, 8'h40, 48'h100);
        u_ata_host_model.send(8'h27, 8'h0, 8'h50, 48'h0);
        // strapped as slave: slave commands answer, master ones do not
        slave_pin = 1'b1;
        repeat (3) @(negedge sys_clk);
        note(1'b0, 2'd0, 24'h0, 4'h0);
        u_ata_host_model.send(8'he5, 8'h0, 8'h50, 48'h0);
        u_ata_host_model.send(8'he5, 8'h0, 8'h40, 48'h0);
        slave_pin = 1'b0;
        repeat (3) @(negedge sys_clk);
        note(1'b0, 2'd0, 24'h0, 4'h0);
        note(1'b0, 2'd0, 24'h0, 4'h0);
        note(1'b1, 2'd1, 24'h0, 4'h0);
        u_ata_host_model.send(8'h27, 8'h0, 8'h40, 48'h0);
        u_ata_host_model.send(8'he5, 8'h0, 8'h40, 48'h0);
        u_ata_host_model.send(8'h37, 8'h0, 8'h40, 48'h100);
        r = $random(seed);
        l2 = {16'h0, 4'h1, r[27:0]};
        set48(l2, 1'b0, 1'b0);
        probe(l2 + 48'h1, 1'b1);
        probe(l2, 1'b0);
        set48(native_cap + 48'h1, 1'b0, 1'b1);
        set48(48'h0000_0fff_ffff, 1'b0, 1'b0);
        sm_locked = 1'b1;
        set48(l2, 1'b0, 1'b1);
        sm_locked = 1'b0;
        sm_frozen = 1'b1;
        set48(l2, 1'b0, 1'b1);
        sm_frozen = 1'b0;
        offset_mode = 1'b1;
        set48(l2, 1'b1, 1'b1);
        set48(l2, 1'b0, 1'b0);
        offset_mode = 1'b0;
        hw_pulse;
        set48(l2, 1'b1, 1'b0);
        set48(l2 - 48'h5, 1'b1, 1'b1);
        hw_pulse;
        set48(l2 - 48'h5, 1'b1, 1'b0);
        hw_pulse;
        r = $random(seed);
        note(1'b0, 2'd0, 24'h0, 4'h0);
        lim = {20'h0, 1'b0, r[26:0]};
        note(1'b0, 2'd2, lim[23:0], lim[27:24]);
        u_ata_host_model.send(8'hf8, 8'h0, 8'h40, 48'h0);
        u_ata_host_model.send(8'hf9, 8'h0, {4'h4, lim[27:24]}, lim);
        note(1'b0, 2'd0, 24'h0, 4'h0);
        lim = 48'h124 * 48'd1008 - 48'd1;
        note(1'b0, 2'd2, 24'h01233f, 4'hf);
        u_ata_host_model.send(8'hf8, 8'h0, 8'h40, 48'h0);
        u_ata_host_model.send(8'hf9, 8'h0, 8'h00, 48'h0123a5);
        set48(l2, 1'b0, 1'b1);
        repeat (5) @(negedge sys_clk);
        chk("notes left", 64'h0, 64'(expq.size()));
        report_and_stop;
    end
endmodule

`default_nettype wire
